// ### core/cbsp_buf2.sv
// Two-entry buffer in the receive byte path.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module cbsp_buf2
  import cbsp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  cbsp_strm_if.snk   in_s,
  cbsp_strm_if.src   out_s
);

  logic [1:0]   cnt_reg,   cnt_next;
  logic [W-1:0] d0_reg,    d0_next;
  logic [W-1:0] d1_reg,    d1_next;
  logic         oval_reg,  oval_next;
  logic         irdy_reg,  irdy_next;
  logic         push;
  logic         pop;

  assign in_s.ready  = irdy_reg;
  assign out_s.valid = oval_reg;
  assign out_s.data  = d0_reg;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    push     = in_s.valid && irdy_reg;
    pop      = oval_reg && out_s.ready;
    cnt_next = cnt_reg;
    d0_next  = d0_reg;
    d1_next  = d1_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
    if (pop) begin
      if (cnt_reg == 2'h2) begin
        d0_next = d1_reg;
      end else if (push) begin
        d0_next = in_s.data;
      end
    end else if (push) begin
      if (cnt_reg == 2'h0) begin
        d0_next = in_s.data;
      end else begin
        d1_next = in_s.data;
      end
    end
    // Flags registered so both handshakes come straight from flops
    oval_next = (cnt_next != 2'h0);
    irdy_next = (cnt_next != 2'h2);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 2'h0;
      d0_reg   <= '0;
      d1_reg   <= '0;
      oval_reg <= 1'b0;
      irdy_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_next;
      d0_reg   <= d0_next;
      d1_reg   <= d1_next;
      oval_reg <= oval_next;
      irdy_reg <= irdy_next;
    end
  end

endmodule

// ### core/cbsp_top.sv
// CAN byte stream port: segments a byte stream into CAN frames and back.
// Assumes a frame-level CAN controller on the ftx/frx side, same clock.
`timescale 1ns/1ps
module cbsp_top
  import cbsp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              txs_valid,
  output logic                   txs_ready,
  input  wire logic [BYTE_W-1:0] txs_data,
  output logic                   rxs_valid,
  input  wire logic              rxs_ready,
  output logic      [BYTE_W-1:0] rxs_data,
  output logic                   ftx_valid,
  input  wire logic              ftx_ready,
  output logic      [BYTE_W-1:0] ftx_data,
  output logic                   ftx_last,
  output logic      [ID_W-1:0]   ftx_id,
  output logic                   ftx_ext,
  output logic                   ftx_fd,
  output logic                   ftx_brs,
  output logic      [DLC_W-1:0]  ftx_dlc,
  input  wire logic              frx_valid,
  output logic                   frx_ready,
  input  wire logic [BYTE_W-1:0] frx_data,
  input  wire logic              frx_first,
  input  wire logic              frx_last,
  input  wire logic [ID_W-1:0]   frx_id,
  input  wire logic              frx_ext,
  input  wire logic              frx_fd,
  output logic                   cfg_en,
  output logic      [BPS_W-1:0]  nom_bps,
  output logic      [BPS_W-1:0]  dat_bps,
  output logic                   wspd_seen
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ID_W-1:0] clamp_id(input logic [ID_W-1:0] id,
                                                input logic ext);
    logic [ID_W-1:0] top;
    top = ext ? EXT_ID_MAX : STD_ID_MAX;
    if (id < ID_MIN) begin
      clamp_id = ID_MIN;
    end else if (id > top) begin
      clamp_id = top;
    end else begin
      clamp_id = id;
    end
  endfunction

  function automatic logic [DLC_W-1:0] len_dlc(input logic [LEN_W-1:0] n);
    if (n <= 7'h08)      len_dlc = n[DLC_W-1:0];
    else if (n <= 7'h0C) len_dlc = 4'h9;
    else if (n <= 7'h10) len_dlc = 4'hA;
    else if (n <= 7'h14) len_dlc = 4'hB;
    else if (n <= 7'h18) len_dlc = 4'hC;
    else if (n <= 7'h20) len_dlc = 4'hD;
    else if (n <= 7'h30) len_dlc = 4'hE;
    else                 len_dlc = 4'hF;
  endfunction

  function automatic logic [LEN_W-1:0] dlc_len(input logic [DLC_W-1:0] d);
    case (d)
      4'h9:    dlc_len = 7'h0C;
      4'hA:    dlc_len = 7'h10;
      4'hB:    dlc_len = 7'h14;
      4'hC:    dlc_len = 7'h18;
      4'hD:    dlc_len = 7'h20;
      4'hE:    dlc_len = 7'h30;
      4'hF:    dlc_len = 7'h40;
      default: dlc_len = {3'h0, d};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register file and Avalon slave
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] sh_ctrl_reg,  sh_ctrl_next;
  logic [ID_W-1:0]   sh_txid_reg,  sh_txid_next;
  logic [ID_W-1:0]   sh_rxid_reg,  sh_rxid_next;
  logic [15:0]       flush_reg,    flush_next;
  logic [CTRL_W-1:0] act_ctrl_reg, act_ctrl_next;
  logic [ID_W-1:0]   act_txid_reg, act_txid_next;
  logic [ID_W-1:0]   act_rxid_reg, act_rxid_next;
  logic              apply_reg,    apply_next;
  logic              wait_reg,     wait_next;
  logic [31:0]       rdata_reg,    rdata_next;
  logic [BPS_W-1:0]  nom_reg,      nom_next;
  logic [BPS_W-1:0]  dat_reg,      dat_next;
  logic              commit;

  cbsp_tx_state_t    t_state_reg;
  cbsp_rx_state_t    r_state_reg;
  logic [CNT_W-1:0]  txcnt_reg;
  logic [CNT_W-1:0]  rxcnt_reg;
  logic [CNT_W-1:0]  wscnt_reg;

  logic en;
  logic ext;
  logic fd;
  assign en  = act_ctrl_reg[B_EN];
  assign ext = act_ctrl_reg[B_EXT];
  assign fd  = act_ctrl_reg[B_FD];

  always_comb begin
    commit        = avs_write && !wait_reg;
    wait_next     = !((avs_read || avs_write) && wait_reg);
    sh_ctrl_next  = sh_ctrl_reg;
    sh_txid_next  = sh_txid_reg;
    sh_rxid_next  = sh_rxid_reg;
    flush_next    = flush_reg;
    apply_next    = 1'b0;
    rdata_next    = rdata_reg;
    act_ctrl_next = act_ctrl_reg;
    act_txid_next = act_txid_reg;
    act_rxid_next = act_rxid_reg;
    if (commit) begin
      case (avs_address)
        OFS_CTRL: begin
          sh_ctrl_next = avs_writedata[CTRL_W-1:0];
          apply_next   = avs_writedata[B_RESTART];
        end
        OFS_TX_ID: sh_txid_next = avs_writedata[ID_W-1:0];
        OFS_RX_ID: sh_rxid_next = avs_writedata[ID_W-1:0];
        OFS_FLUSH: flush_next   = avs_writedata[15:0];
        default:   sh_ctrl_next = sh_ctrl_reg;
      endcase
    end
    // Shadow settings reach the datapath only on restart
    if (apply_reg) begin
      act_ctrl_next = sh_ctrl_reg;
      act_txid_next = clamp_id(sh_txid_reg, sh_ctrl_reg[B_EXT]);
      act_rxid_next = clamp_id(sh_rxid_reg, sh_ctrl_reg[B_EXT]);
    end
    nom_next = BPS_TAB[act_ctrl_reg[F_NOM_HI:F_NOM_LO]];
    dat_next = BPS_TAB[act_ctrl_reg[F_DAT_HI:F_DAT_LO]];
    if ((avs_read || avs_write) && wait_reg) begin
      case (avs_address)
        OFS_CTRL:   rdata_next = {21'h000000, sh_ctrl_reg};
        OFS_TX_ID:  rdata_next = {3'h0, sh_txid_reg};
        OFS_RX_ID:  rdata_next = {3'h0, sh_rxid_reg};
        OFS_FLUSH:  rdata_next = {16'h0000, flush_reg};
        OFS_STATUS: rdata_next = {14'h0000, (r_state_reg == R_PASS),
                                  (t_state_reg == T_SEND), 5'h00, act_ctrl_reg};
        OFS_TX_CNT: rdata_next = {16'h0000, txcnt_reg};
        OFS_RX_CNT: rdata_next = {16'h0000, rxcnt_reg};
        OFS_WS_CNT: rdata_next = {16'h0000, wscnt_reg};
        default:    rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ctrl_reg  <= CTRL_RST;
      sh_txid_reg  <= TXID_RST;
      sh_rxid_reg  <= RXID_RST;
      flush_reg    <= FLUSH_RST;
      act_ctrl_reg <= CTRL_RST;
      act_txid_reg <= TXID_RST;
      act_rxid_reg <= RXID_RST;
      apply_reg    <= 1'b0;
      wait_reg     <= 1'b1;
      rdata_reg    <= 32'h00000000;
      nom_reg      <= '0;
      dat_reg      <= '0;
    end else begin
      sh_ctrl_reg  <= sh_ctrl_next;
      sh_txid_reg  <= sh_txid_next;
      sh_rxid_reg  <= sh_rxid_next;
      flush_reg    <= flush_next;
      act_ctrl_reg <= act_ctrl_next;
      act_txid_reg <= act_txid_next;
      act_rxid_reg <= act_rxid_next;
      apply_reg    <= apply_next;
      wait_reg     <= wait_next;
      rdata_reg    <= rdata_next;
      nom_reg      <= nom_next;
      dat_reg      <= dat_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;
  assign cfg_en          = act_ctrl_reg[B_EN];
  assign nom_bps         = nom_reg;
  assign dat_bps         = dat_reg;

  // ----------------------------------------------------------------
  // Transmit segmenter
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] seg_mem [64];
  cbsp_tx_state_t    t_state_next;
  logic [LEN_W-1:0]  cnt_reg,   cnt_next;
  logic [LEN_W-1:0]  idx_reg,   idx_next;
  logic [LEN_W-1:0]  plen_reg,  plen_next;
  logic [15:0]       idle_reg,  idle_next;
  logic              trdy_reg,  trdy_next;
  logic              fval_reg,  fval_next;
  logic [BYTE_W-1:0] fdat_reg,  fdat_next;
  logic              flast_reg, flast_next;
  logic [ID_W-1:0]   fid_reg,   fid_next;
  logic              fext_reg,  fext_next;
  logic              ffd_reg,   ffd_next;
  logic              fbrs_reg,  fbrs_next;
  logic [DLC_W-1:0]  fdlc_reg,  fdlc_next;
  logic [CNT_W-1:0]  txcnt_next;
  logic              accept;
  logic              flush;
  logic [LEN_W-1:0]  maxlen;
  logic [LEN_W-1:0]  grow;

  always_comb begin
    maxlen       = fd ? FD_MAX : CLASSIC_MAX;
    accept       = txs_valid && trdy_reg;
    grow         = cnt_reg + {6'h00, accept};
    flush        = 1'b0;
    t_state_next = t_state_reg;
    cnt_next     = cnt_reg;
    idx_next     = idx_reg;
    plen_next    = plen_reg;
    idle_next    = idle_reg;
    trdy_next    = 1'b0;
    fval_next    = fval_reg;
    fdat_next    = fdat_reg;
    flast_next   = flast_reg;
    fid_next     = fid_reg;
    fext_next    = fext_reg;
    ffd_next     = ffd_reg;
    fbrs_next    = fbrs_reg;
    fdlc_next    = fdlc_reg;
    txcnt_next   = txcnt_reg;
    case (t_state_reg)
      T_COLLECT: begin
        cnt_next  = grow;
        idle_next = (accept || cnt_reg == 7'h00) ? 16'h0000 : idle_reg + 16'h0001;
        // A quiet stream still flushes its partial frame after the timeout
        flush = (grow == maxlen) ||
                (cnt_reg != 7'h00 && !accept && idle_reg >= flush_reg);
        if (flush) begin
          t_state_next = T_SEND;
          fdlc_next    = len_dlc(grow);
          plen_next    = fd ? dlc_len(len_dlc(grow)) : grow;
          fval_next    = 1'b1;
          fdat_next    = seg_mem[0];
          flast_next   = (plen_next == 7'h01);
          idx_next     = 7'h01;
          fid_next     = act_txid_reg;
          fext_next    = ext;
          ffd_next     = fd;
          fbrs_next    = fd && act_ctrl_reg[B_BRS];
        end
        trdy_next = en && !flush && (grow < maxlen);
      end
      T_SEND: begin
        if (ftx_ready) begin
          if (flast_reg) begin
            t_state_next = T_COLLECT;
            fval_next    = 1'b0;
            flast_next   = 1'b0;
            cnt_next     = 7'h00;
            idle_next    = 16'h0000;
            trdy_next    = en;
            txcnt_next   = txcnt_reg + 16'h0001;
          end else begin
            fdat_next  = (idx_reg < cnt_reg) ? seg_mem[idx_reg[5:0]] : PAD_BYTE;
            flast_next = (idx_reg == plen_reg - 7'h01);
            idx_next   = idx_reg + 7'h01;
          end
        end
      end
      default: t_state_next = T_COLLECT;
    endcase
    // Restart drops any partial segment so old settings never leak out
    if (apply_reg) begin
      t_state_next = T_COLLECT;
      cnt_next     = 7'h00;
      idle_next    = 16'h0000;
      fval_next    = 1'b0;
      flast_next   = 1'b0;
      trdy_next    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (accept && t_state_reg == T_COLLECT) begin
      seg_mem[cnt_reg[5:0]] <= txs_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_state_reg <= T_COLLECT;
      cnt_reg     <= '0;
      idx_reg     <= '0;
      plen_reg    <= '0;
      idle_reg    <= 16'h0000;
      trdy_reg    <= 1'b0;
      fval_reg    <= 1'b0;
      fdat_reg    <= '0;
      flast_reg   <= 1'b0;
      fid_reg     <= '0;
      fext_reg    <= 1'b0;
      ffd_reg     <= 1'b0;
      fbrs_reg    <= 1'b0;
      fdlc_reg    <= '0;
      txcnt_reg   <= '0;
    end else begin
      t_state_reg <= t_state_next;
      cnt_reg     <= cnt_next;
      idx_reg     <= idx_next;
      plen_reg    <= plen_next;
      idle_reg    <= idle_next;
      trdy_reg    <= trdy_next;
      fval_reg    <= fval_next;
      fdat_reg    <= fdat_next;
      flast_reg   <= flast_next;
      fid_reg     <= fid_next;
      fext_reg    <= fext_next;
      ffd_reg     <= ffd_next;
      fbrs_reg    <= fbrs_next;
      fdlc_reg    <= fdlc_next;
      txcnt_reg   <= txcnt_next;
    end
  end

  assign txs_ready = trdy_reg;
  assign ftx_valid = fval_reg;
  assign ftx_data  = fdat_reg;
  assign ftx_last  = flast_reg;
  assign ftx_id    = fid_reg;
  assign ftx_ext   = fext_reg;
  assign ftx_fd    = ffd_reg;
  assign ftx_brs   = fbrs_reg;
  assign ftx_dlc   = fdlc_reg;

  // ----------------------------------------------------------------
  // Receive filter, independent of transmit
  // ----------------------------------------------------------------
  cbsp_strm_if #(.W(BYTE_W)) rb_in ();
  cbsp_strm_if #(.W(BYTE_W)) rb_out ();
  cbsp_rx_state_t   r_state_next;
  logic [CNT_W-1:0] rxcnt_next;
  logic [CNT_W-1:0] wscnt_next;
  logic             ws_reg, ws_next;
  logic             hs;
  logic             hit;
  logic             wsp;

  always_comb begin
    hs  = frx_valid && rb_in.ready;
    hit = en && (frx_ext == ext) && (frx_id == act_rxid_reg);
    wsp = en && !frx_ext && !frx_fd && (frx_id == WSPD_ID);
    rb_in.valid  = frx_valid && (frx_first ? hit : (r_state_reg == R_PASS));
    rb_in.data   = frx_data;
    r_state_next = r_state_reg;
    rxcnt_next   = rxcnt_reg;
    wscnt_next   = wscnt_reg;
    ws_next      = 1'b0;
    if (hs && frx_first) begin
      r_state_next = (hit && !frx_last) ? R_PASS : R_IDLE;
      if (hit) begin
        rxcnt_next = rxcnt_reg + 16'h0001;
      end
      if (wsp) begin
        ws_next    = 1'b1;
        wscnt_next = wscnt_reg + 16'h0001;
      end
    end else if (hs && frx_last) begin
      r_state_next = R_IDLE;
    end
    if (apply_reg) begin
      r_state_next = R_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_state_reg <= R_IDLE;
      rxcnt_reg   <= '0;
      wscnt_reg   <= '0;
      ws_reg      <= 1'b0;
    end else begin
      r_state_reg <= r_state_next;
      rxcnt_reg   <= rxcnt_next;
      wscnt_reg   <= wscnt_next;
      ws_reg      <= ws_next;
    end
  end

  // Filtered frames stall on the buffer, unmatched ones too: simple, lossless
  cbsp_buf2 #(.W(BYTE_W)) u_rxbuf (
    .clk   (clk),
    .rstn  (rstn),
    .in_s  (rb_in),
    .out_s (rb_out)
  );

  assign rb_out.ready = rxs_ready;
  assign rxs_valid    = rb_out.valid;
  assign rxs_data     = rb_out.data;
  assign frx_ready    = rb_in.ready;
  assign wspd_seen    = ws_reg;

endmodule

// ### dv/cbsp_can_node.sv
// CAN node model on the frame side of the port.
// Assumes the port's clock; the bench calls send for incoming frames.
`timescale 1ns/1ps
module cbsp_can_node
  import cbsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        ftx_valid,
  output logic             ftx_ready,
  input  wire logic [7:0]  ftx_data,
  input  wire logic        ftx_last,
  input  wire logic [28:0] ftx_id,
  input  wire logic [3:0]  ftx_dlc,
  input  wire logic        ftx_brs,
  output logic             frx_valid,
  input  wire logic        frx_ready,
  output logic      [7:0]  frx_data,
  output logic             frx_first,
  output logic             frx_last,
  output logic      [28:0] frx_id,
  output logic             frx_ext,
  output logic             frx_fd
);
  logic [7:0]  got[$];
  logic [33:0] hdr[$];
  initial begin
    {frx_valid, frx_first, frx_last, frx_ext, frx_fd, ftx_ready} = '0;
    frx_id = '0;
    frx_data = 8'h5A;
  end
  // Random stalls, as a busy bus would
  always @(posedge clk) ftx_ready <= 1'($urandom);
  always @(posedge clk) begin
    if (ftx_valid && ftx_ready) begin
      got.push_back(ftx_data);
      if (ftx_last) hdr.push_back({ftx_brs, ftx_dlc, ftx_id});
    end
  end
  task automatic send(input logic [28:0] id, input logic ext, input int n, input logic [7:0] b,
                      input logic fd = 1'b0);
    for (int i = 0; i < n; i++) begin
      frx_valid <= 1'b1;
      frx_data <= b + 8'(i);
      frx_first <= (i == 0);
      frx_last <= (i == n - 1);
      frx_id <= id;
      frx_ext <= ext;
      frx_fd <= fd;
      do @(posedge clk); while (!frx_ready);
    end
    frx_valid <= 1'b0;
    // Released line shows no stale byte
    frx_data <= ~frx_data;
    // Idle edge so the next frame never re-raises valid in the same step
    @(posedge clk);
  endtask
endmodule

// ### dv/cbsp_top_assertions.sv
// Checker of the CAN byte stream port, bound to the top module.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
module cbsp_top_assertions
  import cbsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        txs_ready,
  input wire logic        ftx_valid,
  input wire logic        ftx_ready,
  input wire logic [7:0]  ftx_data,
  input wire logic [28:0] ftx_id,
  input wire logic        ftx_ext,
  input wire logic        ftx_fd,
  input wire logic        ftx_brs,
  input wire logic [3:0]  ftx_dlc,
  input wire logic        frx_valid,
  input wire logic        frx_ready,
  input wire logic        frx_first,
  input wire logic [28:0] frx_id,
  input wire logic        frx_ext,
  input wire logic        frx_fd,
  input wire logic        cfg_en,
  input wire logic        wspd_seen
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ws_hdr_s;
    frx_valid && frx_ready && frx_first && frx_id == WSPD_ID && !frx_ext && !frx_fd;
  endsequence
  chk_bus_answer: assert property (req_s |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer late or long");
  chk_beat_hold: assert property (ftx_valid && !ftx_ready |=> ftx_valid && $stable(ftx_data))
    else $error("frame beat dropped");
  chk_hdr_hold: assert property (ftx_valid && !ftx_ready |=> $stable({ftx_id, ftx_dlc}))
    else $error("frame header moved");
  chk_classic_len: assert property (ftx_valid && !ftx_fd |-> ftx_dlc <= 4'h8)
    else $error("classical frame too long");
  chk_brs_gate: assert property (ftx_valid && !ftx_fd |-> !ftx_brs)
    else $error("rate switch without fd");
  chk_tx_id: assert property (ftx_valid |-> ftx_id >= ID_MIN &&
    ftx_id <= (ftx_ext ? EXT_ID_MAX : STD_ID_MAX)) else $error("tx id out of range");
  chk_off_quiet: assert property (!cfg_en [*2] |-> !ftx_valid && !txs_ready)
    else $error("disabled port active");
  chk_wspd_flag: assert property (ws_hdr_s ##0 cfg_en |=> wspd_seen)
    else $error("wheel speed missed");
  chk_wspd_cause: assert property (wspd_seen |->
    $past(frx_valid && frx_ready && frx_first && frx_id == WSPD_ID && !frx_fd))
    else $error("wheel speed spurious");
endmodule
bind cbsp_top cbsp_top_assertions u_cbsp_top_assertions (.*);

// ### dv/cbsp_top_tb_top.sv
// Bench of the CAN byte stream port: registers and both stream directions.
// Assumes the node model on the frame side and one 100 MHz clock.
`timescale 1ns/1ps
module cbsp_top_tb_top
  import cbsp_pkg::*;
  ;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, txs_valid, txs_ready, rxs_valid;
  logic rxs_ready, ftx_valid, ftx_ready, ftx_last, ftx_ext, ftx_fd, ftx_brs, frx_valid;
  logic frx_ready, frx_first, frx_last, frx_ext, frx_fd, cfg_en, wspd_seen;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [7:0]  txs_data, rxs_data, ftx_data, frx_data, exp_q[$], rx_q[$];
  logic [28:0] ftx_id, frx_id;
  logic [3:0]  ftx_dlc;
  logic [19:0] nom_bps, dat_bps;
  int          fail_count, checked, n;
  int          len_t[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
  cbsp_top u_cbsp_top (.*);
  cbsp_can_node u_cbsp_can_node (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) rxs_ready <= 1'($urandom);
  always @(posedge clk) if (rxs_valid && rxs_ready) rx_q.push_back(rxs_data);
  function automatic logic [3:0] dlc_of(input int k);
    for (int c = 0; c < 16; c++) if (len_t[c] >= k) return 4'(c);
    return 4'hF;
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest);
    rv = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic tx_run(input int k, input int tot);
    logic [7:0] b;
    exp_q.delete();
    u_cbsp_can_node.got.delete();
    u_cbsp_can_node.hdr.delete();
    for (int i = 0; i < k; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      txs_valid <= 1'b1;
      txs_data <= b;
      do @(posedge clk); while (!txs_ready);
    end
    txs_valid <= 1'b0;
    repeat (3000) if (u_cbsp_can_node.got.size() < tot) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(u_cbsp_can_node.got.size(), tot, "tx count");
    for (int i = 0; i < tot; i++)
      chk(u_cbsp_can_node.got[i], i < k ? exp_q[i] : PAD_BYTE, "tx byte");
  endtask
  task automatic complete_run();
    $display("checked %0d, failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cut a hang short, far beyond the normal run
  initial begin
    #500000;
    fail_count++;
    complete_run();
  end
  initial begin
    {rstn, avs_read, avs_write, txs_valid, rxs_ready} = '0;
    avs_address = '0;
    avs_writedata = '0;
    txs_data = '0;
    void'($urandom(32'hC907D98B));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, OFS_CTRL, 0);
    chk(rv, CTRL_RST, "ctrl reset");
    chk(nom_bps, BPS_TAB[5], "nom reset");
    bus(0, 5'h01, 0);
    chk(rv, 0, "misaligned");
    $display("register test done");
    bus(1, OFS_TX_ID, 32'h1A5);
    bus(1, OFS_RX_ID, 32'h0C3);
    bus(1, OFS_FLUSH, 32'h4);
    bus(1, OFS_CTRL, 32'h8000_0631);
    repeat (4) @(posedge clk);
    chk(nom_bps, BPS_TAB[3], "nom rate");
    chk(dat_bps, BPS_TAB[6], "dat rate");
    fork
      tx_run(11, 11);
      begin
        u_cbsp_can_node.send(29'h0C3, 1'b0, 6, 8'h30);
        u_cbsp_can_node.send(29'h0C4, 1'b0, 4, 8'h50);
        u_cbsp_can_node.send(29'h0C3, 1'b1, 3, 8'h60);
        u_cbsp_can_node.send(WSPD_ID, 1'b0, 8, 8'h70);
        // Flexible rate frame on the wheel-speed id must not count
        u_cbsp_can_node.send(WSPD_ID, 1'b0, 2, 8'h80, 1'b1);
      end
    join
    chk(u_cbsp_can_node.hdr[1], {5'h03, 29'h1A5}, "tail frame");
    chk(rx_q.size(), 6, "rx count");
    foreach (rx_q[i]) chk(rx_q[i], 8'h30 + 8'(i), "rx byte");
    bus(0, OFS_WS_CNT, 0);
    chk(rv, 1, "wheel count");
    $display("classical test done");
    bus(1, OFS_TX_ID, 32'h1234567);
    bus(1, OFS_CTRL, 32'h8000_075F);
    repeat (4) @(posedge clk);
    n = $urandom_range(20, 9);
    tx_run(n, len_t[dlc_of(n)]);
    chk(u_cbsp_can_node.hdr[0], {1'b1, dlc_of(n), 29'h1234567}, "fd frame");
    $display("fd test done");
    bus(1, OFS_CTRL, 32'h8000_0000);
    repeat (4) @(posedge clk);
    rx_q.delete();
    txs_valid <= 1'b1;
    u_cbsp_can_node.send(29'h0C3, 1'b0, 2, 8'h20);
    // A wrongly passed byte needs a few cycles to leave the buffer
    repeat (8) @(posedge clk);
    chk({cfg_en, txs_ready, rx_q.size() == 0}, 3'h1, "disabled");
    txs_valid <= 1'b0;
    $display("disable test done");
    complete_run();
  end
endmodule

// ### inc/cbsp_pkg.sv
// Constants, register map and field layout of the CAN byte stream port.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
package cbsp_pkg;

  // ----------------------------------------------------------------
  // Frame limits and identifiers
  // ----------------------------------------------------------------
  localparam int          BYTE_W      = 8;
  localparam int          ID_W        = 29;
  localparam int          LEN_W       = 7;
  localparam int          DLC_W       = 4;
  localparam logic [6:0]  CLASSIC_MAX = 7'h08;
  localparam logic [6:0]  FD_MAX      = 7'h40;
  localparam logic [28:0] ID_MIN      = 29'h00000001;
  localparam logic [28:0] STD_ID_MAX  = 29'h000001FF;
  localparam logic [28:0] EXT_ID_MAX  = 29'h1FFFFFFF;
  localparam logic [28:0] WSPD_ID     = 29'h00000146;
  localparam logic [7:0]  PAD_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 5;
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_TX_ID   = 5'h04;
  localparam logic [4:0] OFS_RX_ID   = 5'h08;
  localparam logic [4:0] OFS_FLUSH   = 5'h0C;
  localparam logic [4:0] OFS_STATUS  = 5'h10;
  localparam logic [4:0] OFS_TX_CNT  = 5'h14;
  localparam logic [4:0] OFS_RX_CNT  = 5'h18;
  localparam logic [4:0] OFS_WS_CNT  = 5'h1C;

  // ----------------------------------------------------------------
  // Control field layout
  // ----------------------------------------------------------------
  localparam int CTRL_W      = 11;
  localparam int B_EN        = 0;
  localparam int B_EXT       = 1;
  localparam int B_FD        = 2;
  localparam int B_BRS       = 3;
  localparam int F_NOM_LO    = 4;
  localparam int F_NOM_HI    = 6;
  localparam int F_DAT_LO    = 8;
  localparam int F_DAT_HI    = 10;
  localparam int B_RESTART   = 31;
  localparam int B_TX_BUSY   = 16;
  localparam int B_RX_PASS   = 17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] CTRL_RST  = 11'h051;
  localparam logic [28:0] TXID_RST  = 29'h00000001;
  localparam logic [28:0] RXID_RST  = 29'h00000002;
  localparam logic [15:0] FLUSH_RST = 16'h0064;
  localparam int          CNT_W     = 16;

  // ----------------------------------------------------------------
  // Nominal and data bitrates in bits per second, by select code
  // ----------------------------------------------------------------
  localparam int BPS_W = 20;
  localparam logic [19:0] BPS_TAB [8] = '{
    20'h02710, 20'h04E20, 20'h0C350, 20'h1E848,
    20'h3D090, 20'h7A120, 20'hC3500, 20'hF4240
  };

  typedef enum logic [0:0] {
    T_COLLECT = 1'b0,
    T_SEND    = 1'b1
  } cbsp_tx_state_t;

  typedef enum logic [0:0] {
    R_IDLE = 1'b0,
    R_PASS = 1'b1
  } cbsp_rx_state_t;

endpackage

// ### inc/cbsp_strm_if.sv
// Byte stream carrier with valid and ready between the port's own modules.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cbsp_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
